// file: mme_pkg.sv
// Constants and carrier types for the move and multiply execution block
package mme_pkg;
   // ==========================================
   // Widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   localparam int INSTR_W = 16;
   // ==========================================
   // Opcode fields
   localparam logic [6:0] OPC_STORE = 7'h37;
   localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
   localparam logic [6:0] OPC_MUL_REG = 7'h01;
   localparam int OPC7_POS = 9;
   localparam int OPC8_POS = 8;
   localparam int ACCESS_BIT_POS = 8;
   // ==========================================
   // Addressing
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   // ==========================================
   // Reset values
   localparam logic [7:0] PRODUCT_RESET = 8'h00;
   localparam logic [11:0] ADDR_RESET = 12'h000;
   // ==========================================
   // Types
   typedef enum logic [1:0] {
      OP_NONE,
      OP_STORE,
      OP_MUL_LIT,
      OP_MUL_REG
   } mme_op_type;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic [DATA_W-1:0] wdata;
   } mme_mem_req_type;
   typedef struct packed {
      logic [DATA_W-1:0] high;
      logic [DATA_W-1:0] low;
   } mme_product_type;
endpackage : mme_pkg

// file: mme_mult.sv
// Unsigned 8 by 8 multiplier for the product register pair
`timescale 1ns/10ps
module mme_mult (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   output mme_pkg::mme_product_type p
);
   logic [15:0] full;
   always_comb begin
      full = 16'({8'h00, a} * {8'h00, b});
      p.high = full[15:8];
      p.low = full[7:0];
   end
endmodule : mme_mult

// file: mme_exec.sv
// Execution of store working register and the two multiply instructions
// How it works
// - Multiply by literal: working register times 8-bit literal into product pair.
// - Multiply by literal leaves the working register untouched.
// - Multiply by register: working register times memory byte into product pair.
// - Multiply by register changes neither working register nor memory byte.
// - Multiplies touch no status flag; zero product is not flagged.
// - Access bit clear selects access bank, set selects bank register bank.
// - Multiply by register uses indexed offset when access clear, extended, address <= 5Fh.
// - Store working register uses the same indexed offset switch.
// - One cycle: decode Q1, read Q2, compute Q3, product write Q4.
`timescale 1ns/10ps
module mme_exec (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [15:0] instr_word,
   input wire logic [7:0] working_reg,
   input wire logic [3:0] bank_select_register,
   input wire logic extended_enable,
   input wire logic [11:0] index_base,
   input wire logic [7:0] mem_rdata,
   output mme_pkg::mme_mem_req_type mem_req,
   output mme_pkg::mme_product_type product,
   output logic [1:0] phase,
   output logic done
);
   typedef enum logic [1:0] {
      Q1,
      Q2,
      Q3,
      Q4
   } mme_phase_type;

   // ==========================================
   // Address formation
   function automatic logic [11:0] form_addr(input logic access, input logic [7:0] f,
         input logic ext, input logic [3:0] bank, input logic [11:0] base);
      logic [11:0] r;
      if (access) begin
         r = {bank, f};
      end else if (ext && f <= mme_pkg::INDEXED_LIMIT) begin
         r = 12'(base + {4'h0, f});
      end else if (f <= mme_pkg::INDEXED_LIMIT) begin
         r = {mme_pkg::ACCESS_LOW_BANK, f};
      end else begin
         r = {mme_pkg::ACCESS_HIGH_BANK, f};
      end
      return r;
   endfunction : form_addr

   // ==========================================
   // Opcode decoding
   function automatic mme_pkg::mme_op_type decode_op(input logic [15:0] word);
      mme_pkg::mme_op_type r;
      if (word[15:mme_pkg::OPC7_POS] == mme_pkg::OPC_STORE) begin
         r = mme_pkg::OP_STORE;
      end else if (word[15:mme_pkg::OPC8_POS] == mme_pkg::OPC_MUL_LIT) begin
         r = mme_pkg::OP_MUL_LIT;
      end else if (word[15:mme_pkg::OPC7_POS] == mme_pkg::OPC_MUL_REG) begin
         r = mme_pkg::OP_MUL_REG;
      end else begin
         r = mme_pkg::OP_NONE;
      end
      return r;
   endfunction : decode_op

   // Either multiply
   function automatic logic is_mult(input mme_pkg::mme_op_type op);
      return (op == mme_pkg::OP_MUL_LIT) || (op == mme_pkg::OP_MUL_REG);
   endfunction : is_mult

   // ==========================================
   // State and multiplier
   mme_phase_type phase_reg, phase_next;
   mme_pkg::mme_op_type op_reg, op_next;
   logic [7:0] operand_reg, operand_next;
   logic [7:0] lit_reg, lit_next;
   mme_pkg::mme_product_type prod_calc_reg, prod_calc_next;
   mme_pkg::mme_product_type product_reg, product_next;
   mme_pkg::mme_mem_req_type req_reg, req_next;
   logic done_reg, done_next;
   mme_pkg::mme_product_type mult_out;

   mme_mult mme_mult_i (
      .a(working_reg),
      .b(operand_reg),
      .p(mult_out)
   );

   // ==========================================
   // Phase sequencing
   always_comb begin
      case (phase_reg)
         Q1: begin
            phase_next = Q2;
         end
         Q2: begin
            phase_next = Q3;
         end
         Q3: begin
            phase_next = Q4;
         end
         Q4: begin
            phase_next = Q1;
         end
         default: begin
            phase_next = Q1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         phase_reg <= Q1;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // ==========================================
   // Instruction capture
   always_comb begin
      op_next = op_reg;
      lit_next = lit_reg;
      if (phase_reg == Q1) begin
         op_next = decode_op(instr_word);
         lit_next = instr_word[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         op_reg <= mme_pkg::OP_NONE;
         lit_reg <= mme_pkg::PRODUCT_RESET;
      end else begin
         op_reg <= op_next;
         lit_reg <= lit_next;
      end
   end

   // ==========================================
   // Operand read
   always_comb begin
      operand_next = operand_reg;
      if (phase_reg == Q2) begin
         if (op_reg == mme_pkg::OP_MUL_REG) begin
            operand_next = mem_rdata;
         end else begin
            operand_next = lit_reg;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         operand_reg <= mme_pkg::PRODUCT_RESET;
      end else begin
         operand_reg <= operand_next;
      end
   end

   // ==========================================
   // Product pair
   always_comb begin
      prod_calc_next = prod_calc_reg;
      product_next = product_reg;
      if (phase_reg == Q3 && is_mult(op_reg)) begin
         prod_calc_next = mult_out;
      end
      if (phase_reg == Q4 && is_mult(op_reg)) begin
         product_next = prod_calc_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         prod_calc_reg <= '{high: mme_pkg::PRODUCT_RESET, low: mme_pkg::PRODUCT_RESET};
         product_reg <= '{high: mme_pkg::PRODUCT_RESET, low: mme_pkg::PRODUCT_RESET};
      end else begin
         prod_calc_reg <= prod_calc_next;
         product_reg <= product_next;
      end
   end

   // ==========================================
   // Memory request
   always_comb begin
      req_next = req_reg;
      case (phase_reg)
         Q1: begin
            req_next.rd = (decode_op(instr_word) == mme_pkg::OP_MUL_REG);
            req_next.wr = 1'b0;
            req_next.addr = form_addr(instr_word[mme_pkg::ACCESS_BIT_POS], instr_word[7:0],
               extended_enable, bank_select_register, index_base);
         end
         Q2: begin
            req_next.rd = 1'b0;
         end
         Q3: begin
            if (op_reg == mme_pkg::OP_STORE) begin
               req_next.wr = 1'b1;
               req_next.wdata = working_reg;
            end
         end
         Q4: begin
            req_next.wr = 1'b0;
         end
         default: begin
            req_next.rd = 1'b0;
            req_next.wr = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         req_reg <= '{addr: mme_pkg::ADDR_RESET, rd: 1'b0, wr: 1'b0, wdata: mme_pkg::PRODUCT_RESET};
      end else begin
         req_reg <= req_next;
      end
   end

   // ==========================================
   // Completion pulse
   always_comb begin
      done_next = 1'b0;
      if (phase_reg == Q4) begin
         done_next = (op_reg != mme_pkg::OP_NONE);
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= done_next;
      end
   end

   // ==========================================
   // Outputs
   assign mem_req = req_reg;
   assign product = product_reg;
   assign phase = phase_reg;
   assign done = done_reg;
endmodule : mme_exec

// file: mme_exec_asserts.sv
// Port checks of the execution block
`timescale 1ns/10ps
module mme_exec_chk (
   input logic clock,
   input logic rstn,
   input logic [15:0] instr_word,
   input logic [7:0] working_reg,
   input logic [3:0] bank_select_register,
   input logic extended_enable,
   input logic [11:0] index_base,
   input logic [7:0] mem_rdata,
   input mme_pkg::mme_mem_req_type mem_req,
   input mme_pkg::mme_product_type product,
   input logic [1:0] phase,
   input logic done
);
   // ==========================================
   // Decode
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   wire q1 = phase == 2'h0;
   wire [7:0] f = instr_word[7:0];
   wire lit = q1 && instr_word[15:8] == mme_pkg::OPC_MUL_LIT;
   wire mrg = q1 && instr_word[15:9] == mme_pkg::OPC_MUL_REG;
   wire sto = q1 && instr_word[15:9] == mme_pkg::OPC_STORE;
   wire acc = (mrg || sto) && !instr_word[8];
   wire idx = extended_enable && f <= mme_pkg::INDEXED_LIMIT;
   sequence s_read;
      mem_req.rd ##1 !mem_req.rd;
   endsequence
   sequence s_write;
      mem_req.wr && mem_req.wdata == $past(working_reg) ##1 !mem_req.wr;
   endsequence
   // ==========================================
   // Properties
   property p_lit;
      lit |-> ##4 {product.high, product.low} == 16'($past(working_reg, 2)) * 16'($past(f, 4));
   endproperty
   a_lit: assert property (p_lit) else $error("bad literal product");
   property p_reg;
      mrg |-> ##4 {product.high, product.low} == 16'($past(working_reg, 2)) * 16'($past(mem_rdata, 3));
   endproperty
   a_reg: assert property (p_reg) else $error("bad register product");
   property p_read;
      mrg |=> s_read;
   endproperty
   a_read: assert property (p_read) else $error("bad read");
   property p_write;
      sto |-> ##3 s_write;
   endproperty
   a_write: assert property (p_write) else $error("bad store");
   property p_bank;
      (mrg || sto) && instr_word[8] |=> mem_req.addr == {$past(bank_select_register), $past(f)};
   endproperty
   a_bank: assert property (p_bank) else $error("bad bank address");
   property p_idx;
      acc && idx |=> mem_req.addr == $past(index_base) + 12'($past(f));
   endproperty
   a_idx: assert property (p_idx) else $error("bad indexed address");
   property p_acc;
      acc && !idx |=> mem_req.addr == {$past(f) > 8'h5F ? 4'hF : 4'h0, $past(f)};
   endproperty
   a_acc: assert property (p_acc) else $error("bad access address");
   property p_done;
      lit || mrg || sto |-> ##4 done;
   endproperty
   a_done: assert property (p_done) else $error("missing done");
   property p_nowrite;
      lit || mrg |=> (!mem_req.wr) [*4];
   endproperty
   a_nowrite: assert property (p_nowrite) else $error("multiply wrote memory");
   property p_keep;
      q1 && !lit && !mrg |-> ##4 $stable(product);
   endproperty
   a_keep: assert property (p_keep) else $error("product changed without multiply");
endmodule : mme_exec_chk
bind mme_exec mme_exec_chk mme_exec_chk_i (
   .clock(clock),
   .rstn(rstn),
   .instr_word(instr_word),
   .working_reg(working_reg),
   .bank_select_register(bank_select_register),
   .extended_enable(extended_enable),
   .index_base(index_base),
   .mem_rdata(mem_rdata),
   .mem_req(mem_req),
   .product(product),
   .phase(phase),
   .done(done)
);

// file: test_move_and_multiply_exec.sv
// Self-checking bench of the execution block
`timescale 1ns/10ps
module test_move_and_multiply_exec;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [7:0] working_reg = 8'h00;
   logic [3:0] bank_select_register = 4'h0;
   logic extended_enable = 1'b0;
   logic [11:0] index_base = 12'h000;
   logic [7:0] mem_rdata = 8'h00;
   mme_pkg::mme_mem_req_type mem_req;
   mme_pkg::mme_product_type product;
   logic [1:0] phase;
   logic done;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int prod_q[$];
   int last_prod = 0;
   mme_exec mme_exec_i (
      .clock(clock),
      .rstn(rstn),
      .instr_word(instr_word),
      .working_reg(working_reg),
      .bank_select_register(bank_select_register),
      .extended_enable(extended_enable),
      .index_base(index_base),
      .mem_rdata(mem_rdata),
      .mem_req(mem_req),
      .product(product),
      .phase(phase),
      .done(done)
   );
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         wrap_up();
      end
   end
   task chk(input logic ok);
      n_compared++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR %0t mismatch near phase %0d", $time, phase);
      end
   endtask : chk
   task wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // ==========================================
   // One instruction against the model
   task run(input int kind, input logic [7:0] w, input logic [7:0] f, input logic a, input logic ext);
      logic [11:0] ea;
      logic [7:0] rd;
      chk(phase === 2'h0);
      rd = 8'($urandom);
      bank_select_register = 4'($urandom);
      index_base = 12'($urandom);
      ea = a ? {bank_select_register, f} : f > 8'h5F ? {4'hF, f} : ext ? index_base + 12'(f) : {4'h0, f};
      instr_word = kind == 0 ? {mme_pkg::OPC_STORE, a, f} : kind == 1 ? {mme_pkg::OPC_MUL_LIT, f}
         : kind == 2 ? {mme_pkg::OPC_MUL_REG, a, f} : 16'hFFFF;
      working_reg = w;
      extended_enable = ext;
      mem_rdata = rd;
      if (kind == 1) prod_q.push_back(int'(w) * int'(f));
      if (kind == 2) prod_q.push_back(int'(w) * int'(rd));
      @(negedge clock);
      instr_word = 16'($urandom);
      bank_select_register = 4'($urandom);
      chk(mem_req.rd === (kind == 2));
      if (kind == 2) chk(mem_req.addr === ea);
      repeat (2) @(negedge clock);
      chk(mem_req.wr === (kind == 0));
      if (kind == 0) chk(mem_req.wdata === w && mem_req.addr === ea);
      chk(phase === 2'h3 && done === 1'b0);
      @(negedge clock);
      if (prod_q.size() > 0) last_prod = prod_q.pop_front();
      chk({product.high, product.low} === 16'(last_prod));
      chk(done === (kind != 3));
   endtask : run
   initial begin
      void'($urandom(32'hECF225D7));
      repeat (10) @(negedge clock);
      rstn = 1'b1;
      run(1, 8'hE2, 8'hC4, 1'b0, 1'b0);
      run(1, 8'h00, 8'hC4, 1'b0, 1'b0);
      for (int k = 0; k < 3; k += 2) begin
         for (int i = 0; i < 8; i++) begin
            run(k, 8'($urandom), 8'h5F + 8'(i[0]), i[1], i[2]);
         end
      end
      for (int i = 0; i < 40; i++) begin
         run($urandom % 4, 8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom));
      end
      wrap_up();
   end
endmodule : test_move_and_multiply_exec
